// ### logic/i2c_fe_client.sv
// client end of the two-wire serial memory front end
// assumes the host clocks the bus far slower than clk; core handles content
`timescale 1ns/1ps
`include "i2c_fe_defines.svh"
module i2c_fe_client import i2c_fe_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // two-wire bus
   i2c_fe_if.dev bus,
   // address straps
   input wire logic addr_strap_upper,
   input wire logic addr_strap_lower,
   // memory core inputs
   input wire logic write_busy,
   input wire logic [7:0] rd_data,
   // command report
   output logic cmd_valid,
   output logic cmd_read,
   output region_t cmd_region,
   output logic [16:0] cmd_addr,
   // data bytes
   output logic wr_valid,
   output logic [7:0] wr_byte,
   output logic rd_req,
   // status
   output logic stop_seen,
   output logic standby,
   output logic hs_mode,
   output logic bus_idle
);
   dev_reg_t q, d;
   logic [3:0] pins;
   logic scl;
   logic sda;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic strap_ok;

   i2c_fe_sync #(.W(4)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din({bus.scl, bus.sda, addr_strap_upper, addr_strap_lower}),
      .dout(pins)
   );

   assign scl = pins[3];
   assign sda = pins[2];
   assign rise = scl & ~q.scl_p;
   assign fall = ~scl & q.scl_p;
   assign start = scl & q.scl_p & q.sda_p & ~sda;
   assign stop = scl & q.scl_p & ~q.sda_p & sda;
   assign strap_ok = (q.sh[3] == pins[1]) && (q.sh[2] == pins[0]);

   always_comb begin
      logic ack;
      ack = 1'b0;
      d = q;
      d.cmd_valid = 1'b0;
      d.wr_valid = 1'b0;
      d.rd_req = 1'b0;
      d.stop_seen = 1'b0;
      d.scl_p = scl;
      d.sda_p = sda;
      d.bus_idle = scl & sda;
      if (start) begin
         d.st = ST_ADDR;
         d.cnt = 4'h0;
         d.sda_oe_n = 1'b1;
      end else if (stop) begin
         d.st = ST_STANDBY;
         d.cnt = 4'h0;
         d.sda_oe_n = 1'b1;
         d.main_open = 1'b0;
         d.hs_mode = 1'b0;
         d.stop_seen = 1'b1;
      end else if (rise && q.st != ST_STANDBY) begin
         if (q.cnt == `FE_ACK_BIT && q.st == ST_RDATA && sda) begin
            d.st = ST_STANDBY;
            d.cnt = 4'h0;
         end else begin
            d.sh = {q.sh[6:0], sda};
            d.cnt = q.cnt + 4'h1;
         end
      end else if (fall && q.st != ST_STANDBY) begin
         if (q.cnt == `FE_ACK_BIT) begin
            unique case (q.st)
               ST_ADDR: begin
                  d.rw = q.sh[0];
                  d.nxt = q.sh[0] ? ST_RDATA : ST_WA1;
                  if (q.sh[7:4] == `FE_ID_MAIN && strap_ok) begin
                     ack = 1'b1;
                     d.region = REG_MAIN;
                     d.addr[16] = q.sh[1];
                     d.main_open = 1'b1;
                     d.cmd_valid = q.sh[0];
                  // register region needs closed main command
                  end else if (q.sh[7:4] == `FE_ID_REG && strap_ok && !q.main_open) begin
                     ack = 1'b1;
                     d.region = REG_PEND;
                     d.addr[16] = q.sh[1];
                  // manufacturer code, then address or read
                  end else if (q.sh[7:1] == `FE_MFR_CODE) begin
                     ack = 1'b1;
                     d.region = REG_MFR;
                     d.nxt = q.sh[0] ? ST_RDATA : ST_ADDR;
                     d.cmd_valid = q.sh[0];
                  end else if (q.sh[7:3] == `FE_HS_CODE) begin
                     d.hs_mode = 1'b1;
                     d.nxt = ST_IGNORE;
                  end
               end
               ST_WA1: begin
                  ack = 1'b1;
                  if (q.region == REG_MAIN) begin
                     d.addr[15:8] = q.sh;
                  end else if (q.sh[3:0] == `FE_LOCK_CODE) begin
                     d.region = REG_LOCK;
                  end else if (q.sh[3:2] == `FE_REGION_CODE && !q.sh[7]) begin
                     d.region = REG_SEC;
                     d.addr[15:8] = {6'h00, q.sh[1:0]};
                  end else if (q.sh[3:2] == `FE_REGION_CODE) begin
                     d.region = REG_CFG;
                  end else begin
                     ack = 1'b0;
                  end
                  d.nxt = ST_WA2;
               end
               ST_WA2: begin
                  ack = 1'b1;
                  if (q.region == REG_MAIN || q.region == REG_SEC) begin
                     d.addr[7:0] = q.sh;
                  end
                  d.cmd_valid = 1'b1;
                  d.nxt = ST_WDATA;
               end
               ST_WDATA: begin
                  ack = 1'b1;
                  d.wr_valid = ~write_busy;
                  d.wr_byte = q.sh;
                  d.nxt = ST_WDATA;
               end
               ST_RDATA: begin
                  ack = 1'b0;
                  d.nxt = ST_RDATA;
               end
               ST_IGNORE: begin
                  d.nxt = ST_IGNORE;
               end
               default: begin
                  d.nxt = ST_STANDBY;
               end
            endcase
            if (write_busy) begin
               ack = 1'b0;
            end
            if (q.st == ST_RDATA) begin
               d.sda_oe_n = 1'b1;
            end else if (ack) begin
               d.sda_oe_n = 1'b0;
            end else if (d.nxt != ST_IGNORE) begin
               d.st = ST_STANDBY;
               d.cnt = 4'h0;
               d.sda_oe_n = 1'b1;
            end
         end else if (q.cnt == `FE_ACK_DONE) begin
            d.cnt = 4'h0;
            d.st = q.nxt;
            d.sda_oe_n = 1'b1;
            if (q.nxt == ST_RDATA) begin
               d.tx = rd_data;
               d.sda_oe_n = rd_data[7];
               d.rd_req = 1'b1;
            end
         end else if (q.st == ST_RDATA && q.cnt != 4'h0) begin
            d.sda_oe_n = q.tx[6];
            d.tx = {q.tx[6:0], 1'b0};
         end
      end
      d.standby = (d.st == ST_STANDBY);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: ST_STANDBY, nxt: ST_STANDBY, cnt: 4'h0, sh: `FE_RST_BYTE,
            tx: `FE_RST_BYTE, rw: 1'b0, region: REG_NONE, addr: `FE_RST_ADDR,
            main_open: 1'b0, hs_mode: 1'b0, scl_p: 1'b1, sda_p: 1'b1, sda_oe_n: 1'b1,
            sda_lvl: 1'b0, cmd_valid: 1'b0, wr_valid: 1'b0, wr_byte: `FE_RST_BYTE,
            rd_req: 1'b0, stop_seen: 1'b0, standby: 1'b1, bus_idle: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign bus.dev_sda_oe_n = q.sda_oe_n;
   assign bus.dev_sda_out = q.sda_lvl;
   assign cmd_valid = q.cmd_valid;
   assign cmd_read = q.rw;
   assign cmd_region = q.region;
   assign cmd_addr = q.addr;
   assign wr_valid = q.wr_valid;
   assign wr_byte = q.wr_byte;
   assign rd_req = q.rd_req;
   assign stop_seen = q.stop_seen;
   assign standby = q.standby;
   assign hs_mode = q.hs_mode;
   assign bus_idle = q.bus_idle;
endmodule : i2c_fe_client

// ### logic/i2c_fe_defines.svh
// constants of the two-wire client front end and its host
// assumes inclusion by bare name from the logic folder
`ifndef I2C_FE_DEFINES_SVH
`define I2C_FE_DEFINES_SVH
// device address byte codes
`define FE_ID_MAIN 4'hA
`define FE_ID_REG 4'hB
`define FE_MFR_CODE 7'h7C
`define FE_HS_CODE 5'h01
// first word address byte codes
`define FE_REGION_CODE 2'h2
`define FE_LOCK_CODE 4'h6
// bit counts
`define FE_ACK_BIT 4'h8
`define FE_ACK_DONE 4'h9
`define FE_CLKOUT_MAX 4'h9
// timing
`define FE_CLK_PERIOD_NS 100
`define FE_SCL_PERIOD_NS 10000
`define FE_SCL_QTR ((`FE_SCL_PERIOD_NS) / (4 * `FE_CLK_PERIOD_NS))
// host register offsets
`define FE_REG_CTRL 2'h0
`define FE_REG_TXDATA 2'h1
`define FE_REG_RXDATA 2'h2
`define FE_REG_STATUS 2'h3
// host control fields
`define FE_CTRL_OP_MSB 2
`define FE_CTRL_ACK_BIT 3
`define FE_OP_START 3'h1
`define FE_OP_STOP 3'h2
`define FE_OP_WRITE 3'h3
`define FE_OP_READ 3'h4
`define FE_OP_CLKOUT 3'h5
// reset values
`define FE_RST_BYTE 8'h00
`define FE_RST_ADDR 17'h00000
`endif

// ### logic/i2c_fe_pkg.sv
// types of the two-wire client front end and its host
// assumes nothing beyond the defines header
package i2c_fe_pkg;
   typedef enum logic [2:0] {REG_NONE, REG_MAIN, REG_PEND, REG_SEC, REG_CFG, REG_LOCK,
      REG_MFR} region_t;
   typedef enum logic [2:0] {ST_STANDBY, ST_ADDR, ST_WA1, ST_WA2, ST_WDATA, ST_RDATA,
      ST_IGNORE} dev_state_t;
   typedef enum logic [2:0] {H_IDLE, H_START, H_STOP, H_XFER, H_CLKOUT} host_state_t;
   typedef struct packed {
      dev_state_t st;
      dev_state_t nxt;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic rw;
      region_t region;
      logic [16:0] addr;
      logic main_open;
      logic hs_mode;
      logic scl_p;
      logic sda_p;
      logic sda_oe_n;
      logic sda_lvl;
      logic cmd_valid;
      logic wr_valid;
      logic [7:0] wr_byte;
      logic rd_req;
      logic stop_seen;
      logic standby;
      logic bus_idle;
   } dev_reg_t;
   typedef struct packed {
      host_state_t st;
      logic [1:0] step;
      logic [3:0] bitn;
      logic [5:0] tick;
      logic [7:0] tx;
      logic [7:0] rx;
      logic rd_mode;
      logic send_ack;
      logic nacked;
      logic err;
      logic scl_o;
      logic sda_oe_n;
      logic sda_lvl;
      logic [7:0] rdata;
   } host_reg_t;
endpackage : i2c_fe_pkg

// ### logic/i2c_fe_if.sv
// two-wire bus between host and client
// open drain data line with pull-up; host alone drives the clock
`timescale 1ns/1ps
interface i2c_fe_if;
   logic scl;
   logic host_sda_out;
   logic host_sda_oe_n;
   logic dev_sda_out;
   logic dev_sda_oe_n;
   logic sda;
   // wired and with pull-up
   assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);
   modport host (output scl, output host_sda_out, output host_sda_oe_n, input sda);
   modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe_n);
endinterface : i2c_fe_if

// ### logic/i2c_fe_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes inputs asynchronous to clk
`timescale 1ns/1ps
module i2c_fe_sync #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins and synchronised copies
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } sync_reg_t;
   sync_reg_t q, d;
   always_comb begin
      d.meta = din;
      d.stab = q.meta;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // idle bus level, so no false edge follows reset
         q <= '1;
      end else begin
         q <= d;
      end
   end
   assign dout = q.stab;
endmodule : i2c_fe_sync

// ### logic/i2c_fe_host.sv
// host end of the two-wire bus, driven by software registers
// assumes one client bus; software issues one operation at a time
`timescale 1ns/1ps
`include "i2c_fe_defines.svh"
module i2c_fe_host import i2c_fe_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // two-wire bus
   i2c_fe_if.host bus,
   // register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   host_reg_t q, d;
   logic [1:0] pins;
   logic sda;
   logic adv;

   i2c_fe_sync #(.W(2)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .din({bus.scl, bus.sda}),
      .dout(pins)
   );
   assign sda = pins[0];
   assign adv = (q.st != H_IDLE) && (q.tick == 6'(`FE_SCL_QTR - 1));

   always_comb begin
      d = q;
      d.tick = (q.st == H_IDLE || adv) ? 6'h00 : q.tick + 6'h01;
      if (reg_rd) begin
         unique case (reg_addr)
            `FE_REG_CTRL: d.rdata = 8'h00;
            `FE_REG_TXDATA: d.rdata = q.tx;
            `FE_REG_RXDATA: d.rdata = q.rx;
            `FE_REG_STATUS: d.rdata = {4'h0, pins[1] & sda, q.err, q.nacked,
               q.st != H_IDLE};
         endcase
      end
      if (reg_wr && reg_addr == `FE_REG_TXDATA) begin
         d.tx = reg_wdata;
      end
      // orders while busy are dropped
      if (reg_wr && reg_addr == `FE_REG_CTRL && q.st == H_IDLE) begin
         d.step = 2'h0;
         d.bitn = 4'h0;
         d.err = 1'b0;
         d.send_ack = reg_wdata[`FE_CTRL_ACK_BIT];
         unique case (reg_wdata[`FE_CTRL_OP_MSB:0])
            `FE_OP_START: d.st = H_START;
            `FE_OP_STOP: d.st = H_STOP;
            `FE_OP_WRITE: begin
               d.st = H_XFER;
               d.rd_mode = 1'b0;
               d.nacked = 1'b0;
            end
            `FE_OP_READ: begin
               d.st = H_XFER;
               d.rd_mode = 1'b1;
            end
            `FE_OP_CLKOUT: d.st = H_CLKOUT;
            default: d.st = H_IDLE;
         endcase
      end
      if (adv) begin
         d.step = q.step + 2'h1;
         unique case (q.st)
            H_START: begin
               unique case (q.step)
                  2'h0: d.sda_oe_n = 1'b1;
                  2'h1: d.scl_o = 1'b1;
                  2'h2: begin
                     // start only from a high line
                     if (!sda) begin
                        d.err = 1'b1;
                        d.st = H_IDLE;
                     end else begin
                        d.sda_oe_n = 1'b0;
                     end
                  end
                  2'h3: begin
                     d.scl_o = 1'b0;
                     d.st = H_IDLE;
                  end
               endcase
            end
            H_STOP: begin
               unique case (q.step)
                  2'h0: d.sda_oe_n = 1'b0;
                  2'h1: d.scl_o = 1'b1;
                  2'h2: d.sda_oe_n = 1'b1;
                  2'h3: d.st = H_IDLE;
               endcase
            end
            H_XFER: begin
               unique case (q.step)
                  2'h0: begin
                     if (q.bitn == `FE_ACK_BIT) begin
                        // nack marks the last read byte
                        d.sda_oe_n = q.rd_mode ? ~q.send_ack : 1'b1;
                     end else begin
                        d.sda_oe_n = q.rd_mode ? 1'b1 : q.tx[7];
                     end
                  end
                  2'h1: d.scl_o = 1'b1;
                  2'h2: begin
                     if (q.bitn == `FE_ACK_BIT) begin
                        d.nacked = q.rd_mode ? q.nacked : sda;
                     end else if (q.rd_mode) begin
                        d.rx = {q.rx[6:0], sda};
                     end
                  end
                  2'h3: begin
                     d.scl_o = 1'b0;
                     d.bitn = q.bitn + 4'h1;
                     if (!q.rd_mode) begin
                        d.tx = {q.tx[6:0], 1'b0};
                     end
                     if (q.bitn == `FE_ACK_BIT) begin
                        d.sda_oe_n = 1'b1;
                        d.st = H_IDLE;
                     end
                  end
               endcase
            end
            H_CLKOUT: begin
               unique case (q.step)
                  2'h0: d.sda_oe_n = 1'b1;
                  2'h1: d.scl_o = 1'b1;
                  2'h2: begin
                     if (sda) begin
                        d.st = H_IDLE;
                     end
                     d.bitn = q.bitn + 4'h1;
                  end
                  2'h3: begin
                     d.scl_o = 1'b0;
                     if (q.bitn == `FE_CLKOUT_MAX) begin
                        d.err = 1'b1;
                        d.st = H_IDLE;
                     end
                  end
               endcase
            end
            default: d.step = 2'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: H_IDLE, step: 2'h0, bitn: 4'h0, tick: 6'h00, tx: `FE_RST_BYTE,
            rx: `FE_RST_BYTE, rd_mode: 1'b0, send_ack: 1'b0, nacked: 1'b0, err: 1'b0,
            scl_o: 1'b1, sda_oe_n: 1'b1, sda_lvl: 1'b0, rdata: `FE_RST_BYTE};
      end else begin
         q <= d;
      end
   end

   assign bus.scl = q.scl_o;
   assign bus.host_sda_oe_n = q.sda_oe_n;
   assign bus.host_sda_out = q.sda_lvl;
   assign reg_rdata = q.rdata;
endmodule : i2c_fe_host

// ### testbench/i2c_fe_link_props.sv
// checker of the two-wire link joining host and client
// assumes the shared interface signals and client status, one clock domain
`timescale 1ns/1ps
module i2c_fe_link_props (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link signals
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe_n,
   // client side
   input wire logic write_busy,
   input wire logic cmd_valid,
   input wire logic stop_seen,
   input wire logic standby,
   input wire logic bus_idle
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // clock rises while the client holds data low
   logic [3:0] low_q;
   logic [3:0] low_d;
   logic scl_q;
   always_comb begin
      low_d = dev_sda_oe_n ? 4'h0 : low_q + {3'h0, scl & ~scl_q};
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_q <= 4'h0;
         scl_q <= 1'b1;
      end else begin
         low_q <= low_d;
         scl_q <= scl;
      end
   end
   sequence stop_cond;
      scl && $rose(sda);
   endsequence
   sequence ack_phase;
      $rose(scl) && !dev_sda_oe_n;
   endsequence
   idle_level_a: assert property ((scl && sda) [*6] |=> bus_idle)
      else $error("idle flag missing with both lines high");
   idle_drop_a: assert property (!(scl && sda) |-> ##[1:4] !bus_idle)
      else $error("idle flag kept with a line low");
   stop_detect_a: assert property (stop_cond |-> ##[1:6] stop_seen)
      else $error("stop not reported");
   stop_standby_a: assert property (stop_seen |-> ##[0:2] standby)
      else $error("no standby after stop");
   busy_no_ack_a: assert property (write_busy [*4] |-> dev_sda_oe_n)
      else $error("client drives data while write busy");
   sda_change_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
      else $error("client data changed with clock high");
   ack_hold_a: assert property (ack_phase |-> (!dev_sda_oe_n) [*8])
      else $error("client low level not held in high phase");
   release_bound_a: assert property (low_q <= 4'h9)
      else $error("client held data low over nine clocks");
   cmd_busy_a: assert property (cmd_valid |-> !bus_idle)
      else $error("command reported on an idle bus");
endmodule : i2c_fe_link_props

// ### testbench/eeprom_i2c_client_front_end_bench.sv
// bench joining host and client ends over the shared interface
// assumes software drives the host through its register port
`timescale 1ns/1ps
`include "i2c_fe_defines.svh"
module eeprom_i2c_client_front_end_bench import i2c_fe_pkg::*;;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic strap_u = 1'b0;
   logic strap_l = 1'b0;
   logic write_busy = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic cmd_valid, cmd_read, wr_valid, rd_req, stop_seen, standby, hs_mode, bus_idle;
   region_t cmd_region, c_reg;
   logic [16:0] cmd_addr, c_addr;
   logic [7:0] wr_byte, st;
   logic c_rd, nk;
   logic [7:0] wq[$];
   integer bad_count = 0;
   integer samples_checked = 0;
   integer c_n = 0;
   integer r_n = 0;
   always #50 clk = ~clk;
   i2c_fe_if bus();
   i2c_fe_host i_i2c_fe_host (.clk(clk), .rst_n(rst_n), .bus(bus), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   i2c_fe_client i_i2c_fe_client (.clk(clk), .rst_n(rst_n), .bus(bus),
      .addr_strap_upper(strap_u), .addr_strap_lower(strap_l), .write_busy(write_busy),
      .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
      .cmd_region(cmd_region), .cmd_addr(cmd_addr), .wr_valid(wr_valid),
      .wr_byte(wr_byte), .rd_req(rd_req), .stop_seen(stop_seen), .standby(standby),
      .hs_mode(hs_mode), .bus_idle(bus_idle));
   i2c_fe_link_props i_i2c_fe_link_props (.clk(clk), .rst_n(rst_n), .scl(bus.scl),
      .sda(bus.sda), .dev_sda_oe_n(bus.dev_sda_oe_n), .write_busy(write_busy),
      .cmd_valid(cmd_valid), .stop_seen(stop_seen), .standby(standby), .bus_idle(bus_idle));
   // model side: record each reported command and written byte
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) begin
         c_n = c_n + 1;
         c_reg = cmd_region;
         c_addr = cmd_addr;
         c_rd = cmd_read;
      end
      if (wr_valid === 1'b1) begin
         wq.push_back(wr_byte);
      end
      if (rd_req === 1'b1) begin
         r_n = r_n + 1;
      end
   end
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // strobes rise one edge after entry so back-to-back calls never collide
   task wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task op(input logic [7:0] c);
      integer i;
      wr(`FE_REG_CTRL, c);
      st = 8'hFF;
      for (i = 0; i < 3000 && st[0] !== 1'b0; i++) begin
         rd(`FE_REG_STATUS, st);
      end
      if (st[0] !== 1'b0) begin
         chk(st[0], 0);
         finish_test();
      end
   endtask : op
   task sb(input logic [7:0] b);
      wr(`FE_REG_TXDATA, b);
      op({5'h0, `FE_OP_WRITE});
      nk = st[1];
   endtask : sb
   task cmd(input logic [7:0] d, input logic [7:0] w1, input logic [7:0] w2, input logic en);
      op({5'h0, `FE_OP_START});
      sb(d);
      chk(nk, !en);
      if (en) begin
         sb(w1);
         chk(nk, 0);
         sb(w2);
         chk(nk, 0);
      end
   endtask : cmd
   // client sees pin edges three clocks late
   task stop;
      op({5'h0, `FE_OP_STOP});
      repeat (4) @(posedge clk);
      chk(standby, 1);
   endtask : stop
   initial begin
      integer i;
      integer n0;
      logic [7:0] w1, w2, dt, x;
      logic top;
      logic [1:0] hw;
      region_t er;
      void'($urandom(32'h5886CB03));
      hw = 2'($urandom);
      x = 8'($urandom_range(3, 1));
      strap_u <= hw[1];
      strap_l <= hw[0];
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (i = 0; i < 3; i++) begin
         w1 = 8'($urandom);
         w2 = 8'($urandom);
         dt = 8'($urandom);
         top = 1'($urandom);
         n0 = c_n;
         cmd({`FE_ID_MAIN, hw, top, 1'b0}, w1, w2, 1'b1);
         sb(dt);
         chk(nk, 0);
         stop();
         chk(c_n - n0, 1);
         chk(c_reg, REG_MAIN);
         chk(c_addr, {top, w1, w2});
         chk(c_rd, 0);
         chk(wq.size(), 1);
         chk(wq.pop_front(), dt);
      end
      $display("main writes done");
      for (i = 0; i < 3; i++) begin
         w1 = 8'($urandom);
         w2 = 8'($urandom);
         top = 1'($urandom);
         w1 = i == 0 ? {1'b0, w1[6:4], `FE_REGION_CODE, w1[1:0]} :
            i == 1 ? {1'b1, w1[6:4], `FE_REGION_CODE, w1[1:0]} : {w1[7:4], `FE_LOCK_CODE};
         er = i == 0 ? REG_SEC : i == 1 ? REG_CFG : REG_LOCK;
         n0 = c_n;
         cmd({`FE_ID_REG, hw, top, 1'b0}, w1, w2, 1'b1);
         stop();
         chk(c_n - n0, 1);
         chk(c_reg, er);
         if (i == 0) chk(c_addr, {top, 6'h00, w1[1:0], w2});
      end
      $display("register regions done");
      cmd({`FE_ID_MAIN, hw ^ x[1:0], 2'h0}, 8'h00, 8'h00, 1'b0);
      stop();
      @(posedge clk);
      write_busy <= 1'b1;
      cmd({`FE_ID_MAIN, hw, 2'h0}, 8'h00, 8'h00, 1'b0);
      @(posedge clk);
      write_busy <= 1'b0;
      stop();
      cmd({`FE_ID_MAIN, hw, 2'h0}, w1, w2, 1'b1);
      cmd({`FE_ID_REG, hw, 2'h0}, 8'h08, w2, 1'b0);
      stop();
      op({5'h0, `FE_OP_START});
      sb({`FE_HS_CODE, x[2:0]});
      chk(nk, 1);
      chk(hs_mode, 1);
      stop();
      chk(hs_mode, 0);
      op({5'h0, `FE_OP_START});
      sb({`FE_MFR_CODE, 1'b0});
      chk(nk, 0);
      stop();
      $display("refusals and host codes done");
      dt = 8'($urandom);
      @(posedge clk);
      rd_data <= dt;
      n0 = c_n;
      op({5'h0, `FE_OP_START});
      sb({`FE_ID_MAIN, hw, top, 1'b1});
      chk(nk, 0);
      op({4'h0, 1'b0, `FE_OP_READ});
      rd(`FE_REG_RXDATA, w1);
      chk(w1, dt);
      stop();
      chk(c_n - n0, 1);
      chk(c_rd, 1);
      chk(r_n, 1);
      @(posedge clk);
      rd_data <= 8'h00;
      op({5'h0, `FE_OP_START});
      sb({`FE_ID_MAIN, hw, top, 1'b1});
      op({4'h0, 1'b1, `FE_OP_READ});
      op({5'h0, `FE_OP_CLKOUT});
      chk(st[2], 0);
      chk(r_n, 3);
      n0 = c_n;
      cmd({`FE_ID_MAIN, hw, top, 1'b0}, w1, w2, 1'b1);
      stop();
      chk(c_n - n0, 1);
      chk(c_addr, {top, w1, w2});
      $display("read and recovery done");
      finish_test();
   end
endmodule : eeprom_i2c_client_front_end_bench
